// ===== core/sample_fifo.v
`timescale 1ns/1ps
`default_nettype none
// =====================================
// small synchronous fifo
module sample_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // clock and reset
   input wire mclk,
   input wire srst,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   localparam [AW:0] FULL_COUNT = DEPTH;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   reg out_full;
   wire do_wr;
   wire do_rd;
   wire do_load;
   // out_data is a register stage in front of the storage
   assign in_ready = (count != FULL_COUNT);
   assign out_valid = out_full;
   assign do_load = (count != {(AW+1){1'b0}}) && (!out_full || out_ready);
   assign do_wr = in_valid && in_ready;
   assign do_rd = do_load;
   always @(posedge mclk) begin
      if (srst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         out_full <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end else begin
         if (do_wr) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            out_data <= mem[rd_ptr];
            rd_ptr <= rd_ptr + 1'b1;
            out_full <= 1'b1;
         end else if (out_ready) begin
            out_full <= 1'b0;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (!do_wr && do_rd) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // sample_fifo
`default_nettype wire

// ===== core/sar_adc_consts.vh
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
// serial frame layout, counted in serial-clock falling edges after the start
`define HOLD_EDGE 5'h03
`define MSB_EDGE 5'h04
`define LSB_EDGE 5'h0B
`define FRAME_EDGE 5'h10
`define LEAD_ZEROS 4'h4
`define RESULT_BITS 4'h8
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define SAMPLE_WIDTH 8
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define BIPOLAR_FLIP 8'h80
`define BYTE_ZERO 8'h00
`define SYNC_ZERO 2'h0
`define SYNC_ONE 2'h3
`define MSB_INDEX 3'h7
`endif

// ===== core/sar_adc_serial_readout.v
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.vh"
module sar_adc_serial_readout (
   // clock and reset
   input wire mclk,
   input wire srst,
   // serial pins
   input wire sclk,
   input wire cs_n,
   input wire oe_n,
   output reg dout_o,
   output reg dout_oe,
   // mode pins
   input wire polarity_select,
   input wire channel_select,
   // analog front end model: comparator and control
   input wire [7:0] analog_input_first,
   input wire [7:0] analog_input_second,
   output reg powered,
   output reg tracking,
   output reg channel_sel,
   // converted samples out
   output wire sample_valid,
   input wire sample_ready,
   output wire [7:0] sample_data,
   output wire sample_dropped_busy
);
   // =====================================
   // pin synchronisers
   reg [1:0] sclk_s;
   reg [1:0] cs_s;
   reg [1:0] oe_s;
   reg [1:0] pol_s;
   reg [1:0] ch_s;
   reg sclk_d;
   reg cs_d;
   always @(posedge mclk) begin
      if (srst) begin
         sclk_s <= `SYNC_ZERO;
         cs_s <= `SYNC_ONE;
         oe_s <= `SYNC_ONE;
         pol_s <= `SYNC_ZERO;
         ch_s <= `SYNC_ZERO;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[0], sclk};
         cs_s <= {cs_s[0], cs_n};
         oe_s <= {oe_s[0], oe_n};
         pol_s <= {pol_s[0], polarity_select};
         ch_s <= {ch_s[0], channel_select};
         sclk_d <= sclk_s[1];
         cs_d <= cs_s[1];
      end
   end

   // =====================================
   // edge detection on the synchronised pins
   function edge_fell;
      input was;
      input now;
      begin
         edge_fell = was && !now;
      end
   endfunction

   function edge_rose;
      input was;
      input now;
      begin
         edge_rose = !was && now;
      end
   endfunction

   wire sclk_fall = edge_fell(sclk_d, sclk_s[1]);
   wire sclk_rise = edge_rose(sclk_d, sclk_s[1]);
   wire cs_fall = edge_fell(cs_d, cs_s[1]);
   wire oe_high = oe_s[1];

   // =====================================
   // sequencer
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_TAIL = 2'h2;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [4:0] fall_cnt;
   reg [4:0] rise_cnt;
   reg [7:0] held;
   reg [7:0] sar;
   reg unipolar;
   reg push;
   reg [7:0] push_data;
   reg dropped;
   wire fifo_ready;

   // straight binary or two's complement coding
   function [7:0] code_sample;
      input [7:0] raw;
      input uni;
      begin
         code_sample = uni ? raw : (raw ^ `BIPOLAR_FLIP);
      end
   endfunction

   // one more edge on an edge counter
   function [4:0] count_up;
      input [4:0] cnt;
      begin
         count_up = cnt + `CNT_ONE;
      end
   endfunction

   // result bit decided on a given falling edge, msb on the fourth
   function [2:0] bit_slot;
      input [4:0] edge_no;
      reg [4:0] offset;
      begin
         offset = edge_no - `MSB_EDGE;
         bit_slot = `MSB_INDEX - offset[2:0];
      end
   endfunction

   // =====================================
   // frame decode
   wire [4:0] next_fall = count_up(fall_cnt);
   wire [4:0] next_rise = count_up(rise_cnt);
   wire [2:0] bit_idx = bit_slot(next_fall);
   wire start_ok = cs_fall && !oe_high;
   wire conv_fall = (state == ST_CONV) && sclk_fall && !oe_high;
   wire hold_now = conv_fall && (next_fall == `HOLD_EDGE);
   wire decide = conv_fall && (next_fall >= `MSB_EDGE) && (next_fall <= `LSB_EDGE);
   wire last_bit = conv_fall && (next_fall == `LSB_EDGE);
   wire first_rise = (state == ST_CONV) && sclk_rise && (rise_cnt == `CNT_ZERO) && !oe_high;
   // the lsb stays on the pin until the master has clocked it in
   wire tail_rise = sclk_rise && (next_rise >= `FRAME_EDGE);
   wire tail_fall = sclk_fall && (next_fall == `FRAME_EDGE);
   wire tail_done = (state == ST_TAIL) && !oe_high && (tail_rise || tail_fall);
   wire restart;

   // =====================================
   // next state
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_ok) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            // chip-select falls are not looked at here
            if (last_bit) begin
               next_state = ST_TAIL;
            end
         end
         ST_TAIL: begin
            // a start on the closing edge wins over the end of the tail
            if (start_ok) begin
               next_state = ST_CONV;
            end else if (tail_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (oe_high) begin
         // forced power-down wins over everything
         next_state = ST_IDLE;
      end
   end

   assign restart = (next_state == ST_CONV) && (state != ST_CONV);

   // =====================================
   // state and edge counters
   always @(posedge mclk) begin
      if (srst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         fall_cnt <= `CNT_ZERO;
      end else if (restart) begin
         fall_cnt <= `CNT_ZERO;
      end else if (state != ST_IDLE && sclk_fall) begin
         fall_cnt <= next_fall;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         rise_cnt <= `CNT_ZERO;
      end else if (restart) begin
         rise_cnt <= `CNT_ZERO;
      end else if (state != ST_IDLE && sclk_rise) begin
         rise_cnt <= next_rise;
      end
   end

   // =====================================
   // mode pins, taken on the first rise of a frame
   always @(posedge mclk) begin
      if (srst) begin
         unipolar <= 1'b1;
         channel_sel <= 1'b0;
      end else if (first_rise) begin
         unipolar <= pol_s[1];
         channel_sel <= ch_s[1];
      end
   end

   // =====================================
   // power, track and output drive
   always @(posedge mclk) begin
      if (srst) begin
         powered <= 1'b0;
         tracking <= 1'b0;
         dout_oe <= 1'b0;
      end else if (oe_high) begin
         powered <= 1'b0;
         tracking <= 1'b0;
         dout_oe <= 1'b0;
      end else if (restart) begin
         powered <= 1'b1;
         tracking <= 1'b1;
         dout_oe <= 1'b1;
      end else begin
         if (hold_now) begin
            tracking <= 1'b0;
         end
         if (last_bit) begin
            powered <= 1'b0;
         end
      end
   end

   // =====================================
   // sample, bit decisions and serial output
   always @(posedge mclk) begin
      if (srst) begin
         held <= `BYTE_ZERO;
         sar <= `BYTE_ZERO;
         dout_o <= 1'b0;
      end else if (oe_high) begin
         dout_o <= 1'b0;
      end else if (restart) begin
         sar <= `BYTE_ZERO;
         dout_o <= 1'b0;
      end else begin
         if (hold_now) begin
            held <= code_sample(channel_sel ? analog_input_second : analog_input_first,
               unipolar || channel_sel);
         end
         if (decide) begin
            // bit decision, msb first, changes on falling edge
            dout_o <= held[bit_idx];
            sar[bit_idx] <= held[bit_idx];
         end
         if (tail_done) begin
            dout_o <= 1'b0;
         end
      end
   end

   // =====================================
   // hand the result to the buffer
   always @(posedge mclk) begin
      if (srst) begin
         push <= 1'b0;
         push_data <= `BYTE_ZERO;
         dropped <= 1'b0;
      end else begin
         push <= last_bit;
         dropped <= last_bit && !fifo_ready;
         if (last_bit) begin
            push_data <= {sar[7:1], held[0]};
         end
      end
   end

   assign sample_dropped_busy = dropped;

   // =====================================
   // result buffer
   sample_fifo #(
      .WIDTH(`SAMPLE_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_data),
      .out_valid(sample_valid),
      .out_ready(sample_ready),
      .out_data(sample_data)
   );
endmodule // sar_adc_serial_readout
`default_nettype wire

// ===== test/sar_adc_readout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ===
// readout checker
module sar_adc_readout_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // serial pins, power and track
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic powered,
   input wire logic tracking,
   // samples
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic [7:0] sample_data,
   input wire logic sample_dropped_busy
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   sequence oe_held;
      oe_n[*6];
   endsequence
   sequence pins_quiet;
      ($stable(sclk) && $stable(cs_n) && $stable(oe_n))[*8];
   endsequence
   chk_oe_float: assert property (oe_held |-> !dout_oe)
      else $error("dout driven with enable high");
   chk_oe_power: assert property (oe_held |-> !powered && !tracking)
      else $error("powered with enable high");
   chk_quiet_stable: assert property (pins_quiet |-> $stable(dout_o) && $stable(powered))
      else $error("output moved without pin activity");
   chk_start_enable: assert property ($rose(dout_oe) |-> !oe_n)
      else $error("drive began with enable high");
   chk_power_cause: assert property ($rose(powered) |-> !oe_n && !$past(cs_n, 2))
      else $error("power up without select");
   chk_valid_hold: assert property (sample_valid && !sample_ready |=>
      sample_valid && $stable(sample_data))
      else $error("sample lost while stalled");
   chk_drop_full: assert property (sample_dropped_busy |-> sample_valid)
      else $error("drop with empty buffer");
   chk_drop_pulse: assert property (sample_dropped_busy |=> !sample_dropped_busy)
      else $error("drop flag too long");
   chk_reset_quiet: assert property (disable iff (1'b0)
      srst |=> !dout_oe && !powered && !sample_valid)
      else $error("outputs active after reset");
endmodule // sar_adc_readout_monitor
bind sar_adc_serial_readout sar_adc_readout_monitor i_mon (.mclk(mclk), .srst(srst),
   .sclk(sclk), .cs_n(cs_n), .oe_n(oe_n), .dout_o(dout_o), .dout_oe(dout_oe),
   .powered(powered), .tracking(tracking), .sample_valid(sample_valid),
   .sample_ready(sample_ready), .sample_data(sample_data),
   .sample_dropped_busy(sample_dropped_busy));
`default_nettype wire

// ===== test/sar_adc_serial_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
// ===
// readout bench
module sar_adc_serial_readout_test;
   logic mclk, srst, polarity_select, channel_select, sample_ready, fill;
   logic [7:0] analog_input_first, analog_input_second;
   wire logic sclk, cs_n, oe_n, dout_o, dout_oe, powered, tracking, channel_sel;
   wire logic sample_valid, sample_dropped_busy;
   wire logic [7:0] sample_data;
   int mismatches = 0, total_checks = 0, cycles = 0, drops = 0, seed;
   logic [7:0] expq[$];
   spi_host i_host (.sclk(sclk), .cs_n(cs_n), .oe_n(oe_n), .dout_o(dout_o));
   sar_adc_serial_readout i_dut (.mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
      .oe_n(oe_n), .dout_o(dout_o), .dout_oe(dout_oe), .polarity_select(polarity_select),
      .channel_select(channel_select), .analog_input_first(analog_input_first),
      .analog_input_second(analog_input_second), .powered(powered), .tracking(tracking),
      .channel_sel(channel_sel), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_data(sample_data), .sample_dropped_busy(sample_dropped_busy));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic conv(input bit cpol, glitch, abort, keep, pol, ch, chain);
      logic [15:0] rx;
      logic tail;
      logic [7:0] code;
      @(posedge mclk);
      analog_input_first <= $urandom;
      analog_input_second <= $urandom;
      polarity_select <= pol;
      channel_select <= ch;
      @(posedge mclk);
      code = ch ? analog_input_second : analog_input_first;
      if (!pol && !ch) code = code ^ 8'h80;
      if (!abort && keep) expq.push_back(code);
      i_host.frame(cpol, glitch, abort, chain, rx, tail);
      if (abort) check(dout_oe, 1'b0);
      else begin
         check(cpol ? rx[15:5] : rx[15:4], cpol ? {3'h0, code} : {4'h0, code});
         check(tail, 1'b0);
         check(powered, chain);
         check(tracking, chain);
         check(channel_sel, ch);
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // timeout, stall pattern and result watcher
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      sample_ready <= fill ? 1'b0 : 1'($urandom);
      if (cycles > 20000) begin
         mismatches++;
         close_out;
      end
      if (sample_dropped_busy === 1'b1) drops++;
      if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
         if (expq.size() == 0) check(1'b1, 1'b0);
         else check(sample_data, expq.pop_front());
      end
   end
   initial begin
      seed = $urandom(32'hF385636A);
      srst = 1'b1;
      fill = 1'b0;
      polarity_select = 1'b0;
      channel_select = 1'b0;
      analog_input_first = 8'h00;
      analog_input_second = 8'h00;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      repeat (6) @(posedge mclk);
      for (int m = 0; m < 8; m++) conv(m[0], m[1], 1'b0, 1'b1, m[2], m[1], 1'b0);
      conv(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      conv(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      conv(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      fill = 1'b1;
      repeat (40) @(posedge mclk);
      // four stored words plus the output register hold five results
      for (int k = 0; k < 6; k++) conv(k[0], 1'b0, 1'b0, k < 5, $urandom, $urandom, 1'b0);
      check(drops, 1);
      fill = 1'b0;
      repeat (40) @(posedge mclk);
      check(expq.size(), 0);
      close_out;
   end
endmodule // sar_adc_serial_readout_test
`default_nettype wire

// ===== test/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ===
// serial master: 200 ns clock, samples dout on rises
module spi_host (
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic oe_n,
   input wire logic dout_o
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      oe_n = 1'b1;
   end
   bit linked = 1'b0;
   // low phase longer so dout settles before the rise
   task automatic frame(input bit cpol, input bit glitch, input bit abort, input bit chain,
         output logic [15:0] rx, output logic tail);
      if (!linked) begin
         sclk = cpol;
         #200;
         cs_n = 1'b0;
         oe_n = 1'b0;
         #130;
      end
      linked = 1'b0;
      for (int i = 0; i < 16; i++) begin
         sclk = 1'b0;
         #130;
         sclk = 1'b1;
         rx = {rx[14:0], dout_o};
         if (glitch && i == 2) cs_n = 1'b1;
         if (glitch && i == 4) cs_n = 1'b0;
         if (abort && i == 6) oe_n = 1'b1;
         if (chain && i == 12) cs_n = 1'b1;
         #70;
      end
      sclk = cpol;
      // next start lands on the sixteenth fall, enable stays low
      if (chain) cs_n = 1'b0;
      #300;
      tail = dout_o;
      if (chain) linked = 1'b1;
      else begin
         cs_n = 1'b1;
         oe_n = 1'b1;
      end
   endtask
endmodule // spi_host
`default_nettype wire
